// ---- include/chan_cfg_pkg.sv ----
/*
  Package for the per-channel local configuration register bank:
  register offsets, field positions, reset values and timing constants.
  Assumes a 40 MHz core clock.
*/
package chan_cfg_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned NUM_CHAN = 8;
  localparam int unsigned NUM_REGS = 8;
  localparam logic [2:0] OFS_COEF_SEL = 3'h0;
  localparam logic [2:0] OFS_LOOP_IRQ = 3'h1;
  localparam logic [2:0] OFS_TTX_GAIN = 3'h2;
  localparam logic [2:0] OFS_DEBOUNCE = 3'h3;
  localparam logic [2:0] OFS_T0_LOW = 3'h4;
  localparam logic [2:0] OFS_T_MIXED = 3'h5;
  localparam logic [2:0] OFS_T1_HIGH = 3'h6;
  localparam logic [2:0] OFS_TONE_CTRL = 3'h7;
  localparam logic [7:0] RST_COEF_SEL = 8'h08;
  localparam logic [7:0] RST_OTHER = 8'h00;
  localparam int unsigned B_HPF = 3;
  localparam int unsigned B_RX_CUT = 3;
  localparam int unsigned B_IE_LO = 4;
  localparam int unsigned B_T0_ON = 6;
  localparam int unsigned B_T1_ON = 7;
  localparam int unsigned DEB_STEP_MS = 2;
  localparam int unsigned DEB_STEP_CYC = CLK_HZ / 1000 * DEB_STEP_MS;
  localparam int unsigned IE_SB2 = 0;
  localparam int unsigned IE_SB1 = 1;
  localparam int unsigned IE_GK = 2;
  localparam int unsigned IE_HOOK = 3;
endpackage

// ---- hw/channel_local_config_regs.sv ----
/*
  Per-channel local configuration register bank of an eight-channel codec,
  with hook and ground-key debouncing and line-input interrupt gating.
  Assumes the command decoder delivers a one-cycle write or read strobe
  with channel and offset on i_clk; line inputs arrive asynchronously.
*/
// How it works
// - Bits 0..2 select memory coefficients for match, echo, scaling; clear disables.
// - Bit 3 enables the high-pass filter, resets to one.
// - Bits 4 and 6 enable tx and rx frequency correction, else bypassed.
// - Bits 5 and 7 take tx and rx gain from memory, else unity.
// - Loop bits 0 and 1 enable digital and analog one-bit loopbacks.
// - Loop bit 2 retransmits received highway data per time-slot settings.
// - Receive cutoff bit disconnects the channel's PCM receive path.
// - Bits 4..7 gate interrupts of pin2, pin1, ground key, hook.
// - Teletax gain code scales output linearly, zero to unity.
// - Low debounce nibble sets hook debounce as code times 2 ms.
// - High debounce nibble sets ground-key debounce as code times 2 ms.
// - Tone 0 frequency is register 4 plus low nibble of register 5.
// - Tone 1 frequency is high nibble of register 5 plus register 6.
// - Six-bit tone gain code drives the dual-tone output gain.
// - Setting a tone enable starts that tone at a zero crossing.
// - Clearing a tone enable stops that tone at its peak.
`timescale 1ns/10ps
module channel_local_config_regs
  import chan_cfg_pkg::*;
#(
  parameter int unsigned DEB_STEP = DEB_STEP_CYC
)
(
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  input  wire logic [2:0]             i_chan,
  input  wire logic [2:0]             i_addr,
  input  wire logic [7:0]             i_wdata,
  output logic      [7:0]             o_rdata,
  output logic                        o_rvalid,
  input  wire logic [NUM_CHAN-1:0]    i_hook_input,
  input  wire logic [NUM_CHAN-1:0]    i_ground_key_input,
  input  wire logic [NUM_CHAN-1:0]    i_bidir_line_pin_1,
  input  wire logic [NUM_CHAN-1:0]    i_bidir_line_pin_2,
  input  wire logic [NUM_CHAN-1:0]    i_pin1_is_input,
  input  wire logic [NUM_CHAN-1:0]    i_pin2_is_input,
  input  wire logic [NUM_CHAN-1:0]    i_tone0_zero_cross,
  input  wire logic [NUM_CHAN-1:0]    i_tone1_zero_cross,
  input  wire logic [NUM_CHAN-1:0]    i_tone0_peak,
  input  wire logic [NUM_CHAN-1:0]    i_tone1_peak,
  output logic      [NUM_CHAN*8-1:0]  o_coef_select,
  output logic      [NUM_CHAN*3-1:0]  o_channel_loop_ctrl_bits,
  output logic      [NUM_CHAN-1:0]    o_receive_cutoff_bit,
  output logic      [NUM_CHAN*8-1:0]  o_teletax_gain_bits,
  output logic      [NUM_CHAN*12-1:0] o_tone0_frequency,
  output logic      [NUM_CHAN*12-1:0] o_tone1_frequency,
  output logic      [NUM_CHAN*6-1:0]  o_tone_gain_bits,
  output logic      [NUM_CHAN-1:0]    o_tone0_run,
  output logic      [NUM_CHAN-1:0]    o_tone1_run,
  output logic      [NUM_CHAN-1:0]    o_hook_debounced,
  output logic      [NUM_CHAN-1:0]    o_ground_key_debounced,
  output logic      [NUM_CHAN-1:0]    o_line_event
);

  initial
  begin
    // Tick counter is 17 bits so the default 2 ms step at 40 MHz fits
    if (DEB_STEP < 1 || DEB_STEP > 131071)
      $error("DEB_STEP out of range");
  end

  typedef struct packed {
    logic [NUM_CHAN-1:0][NUM_REGS-1:0][7:0] regs;
    logic [7:0]                             rdata;
    logic                                   rvalid;
    logic [16:0]                            tick_cnt;
    logic [NUM_CHAN-1:0][3:0]               in_s1;
    logic [NUM_CHAN-1:0][3:0]               in_s2;
    logic [NUM_CHAN-1:0][1:0]               pin_prev;
    logic [NUM_CHAN-1:0]                    hook_stable;
    logic [NUM_CHAN-1:0]                    gk_stable;
    logic [NUM_CHAN-1:0][4:0]               hook_cnt;
    logic [NUM_CHAN-1:0][4:0]               gk_cnt;
    logic [NUM_CHAN-1:0]                    t0_run;
    logic [NUM_CHAN-1:0]                    t1_run;
    logic [NUM_CHAN-1:0]                    event_p;
  } state_s;

  state_s st_q;
  state_s st_d;

  logic tick;
  assign tick = (st_q.tick_cnt == 17'(DEB_STEP - 1));

  always_comb
  begin
    logic [3:0] raw;
    logic [3:0] hook_lim;
    logic [3:0] gk_lim;
    logic [7:0] ctl;
    raw      = 4'h0;
    hook_lim = 4'h0;
    gk_lim   = 4'h0;
    ctl      = 8'h00;
    st_d = st_q;
    st_d.rvalid = 1'b0;
    st_d.event_p = '0;
    st_d.tick_cnt = tick ? 17'h00000 : st_q.tick_cnt + 17'h00001;
    if (i_wr)
      st_d.regs[i_chan][i_addr] = i_wdata;
    if (i_rd)
    begin
      st_d.rdata  = st_q.regs[i_chan][i_addr];
      st_d.rvalid = 1'b1;
    end
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      raw = {i_bidir_line_pin_2[c], i_bidir_line_pin_1[c],
             i_ground_key_input[c], i_hook_input[c]};
      st_d.in_s1[c] = raw;
      st_d.in_s2[c] = st_q.in_s1[c];
      hook_lim = st_q.regs[c][OFS_DEBOUNCE][3:0];
      gk_lim   = st_q.regs[c][OFS_DEBOUNCE][7:4];
      ctl      = st_q.regs[c][OFS_LOOP_IRQ];
      // Hook: counter restarts whenever the input matches the debounced level again
      if (st_q.in_s2[c][0] == st_q.hook_stable[c])
        st_d.hook_cnt[c] = 5'h00;
      else if ({1'b0, hook_lim} <= st_q.hook_cnt[c])
      begin
        st_d.hook_stable[c] = st_q.in_s2[c][0];
        st_d.hook_cnt[c] = 5'h00;
        if (ctl[B_IE_LO + IE_HOOK])
          st_d.event_p[c] = 1'b1;
      end
      else if (tick)
        st_d.hook_cnt[c] = st_q.hook_cnt[c] + 5'h01;
      if (st_q.in_s2[c][1] == st_q.gk_stable[c])
        st_d.gk_cnt[c] = 5'h00;
      else if ({1'b0, gk_lim} <= st_q.gk_cnt[c])
      begin
        st_d.gk_stable[c] = st_q.in_s2[c][1];
        st_d.gk_cnt[c] = 5'h00;
        if (ctl[B_IE_LO + IE_GK])
          st_d.event_p[c] = 1'b1;
      end
      else if (tick)
        st_d.gk_cnt[c] = st_q.gk_cnt[c] + 5'h01;
      // Bidirectional pins only count while configured as inputs
      st_d.pin_prev[c] = st_q.in_s2[c][3:2];
      if ((ctl[B_IE_LO + IE_SB1] && i_pin1_is_input[c] &&
           st_q.pin_prev[c][0] != st_q.in_s2[c][2]) ||
          (ctl[B_IE_LO + IE_SB2] && i_pin2_is_input[c] &&
           st_q.pin_prev[c][1] != st_q.in_s2[c][3]))
        st_d.event_p[c] = 1'b1;
      // Start waits for a zero crossing, stop waits for the peak
      if (st_q.regs[c][OFS_TONE_CTRL][B_T0_ON] && i_tone0_zero_cross[c])
        st_d.t0_run[c] = 1'b1;
      else if (!st_q.regs[c][OFS_TONE_CTRL][B_T0_ON] && i_tone0_peak[c])
        st_d.t0_run[c] = 1'b0;
      if (st_q.regs[c][OFS_TONE_CTRL][B_T1_ON] && i_tone1_zero_cross[c])
        st_d.t1_run[c] = 1'b1;
      else if (!st_q.regs[c][OFS_TONE_CTRL][B_T1_ON] && i_tone1_peak[c])
        st_d.t1_run[c] = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q <= '0;
      for (int c = 0; c < NUM_CHAN; c++)
        st_q.regs[c][OFS_COEF_SEL] <= RST_COEF_SEL;
    end
    else
      st_q <= st_d;
  end

  generate
    for (genvar c = 0; c < NUM_CHAN; c++)
    begin : g_out
      // is software's duty; bits pass unmodified
      assign o_coef_select[c*8 +: 8] = st_q.regs[c][OFS_COEF_SEL];
      assign o_channel_loop_ctrl_bits[c*3 +: 3] = st_q.regs[c][OFS_LOOP_IRQ][2:0];
      assign o_receive_cutoff_bit[c] = st_q.regs[c][OFS_LOOP_IRQ][B_RX_CUT];
      assign o_teletax_gain_bits[c*8 +: 8] = st_q.regs[c][OFS_TTX_GAIN];
      assign o_tone0_frequency[c*12 +: 12] =
        {st_q.regs[c][OFS_T_MIXED][3:0], st_q.regs[c][OFS_T0_LOW]};
      assign o_tone1_frequency[c*12 +: 12] =
        {st_q.regs[c][OFS_T1_HIGH], st_q.regs[c][OFS_T_MIXED][7:4]};
      assign o_tone_gain_bits[c*6 +: 6] = st_q.regs[c][OFS_TONE_CTRL][5:0];
    end
  endgenerate

  assign o_rdata = st_q.rdata;
  assign o_rvalid = st_q.rvalid;
  assign o_tone0_run = st_q.t0_run;
  assign o_tone1_run = st_q.t1_run;
  assign o_hook_debounced = st_q.hook_stable;
  assign o_ground_key_debounced = st_q.gk_stable;
  assign o_line_event = st_q.event_p;

endmodule

// ---- tb/cfg_regs_monitor.sv ----
/* Port assertions for the channel configuration bank.
   Bound into every bank instance; drives nothing. */
`timescale 1ns/10ps
module cfg_regs_monitor
  import chan_cfg_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [2:0]  i_chan,
  input wire logic [2:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        o_rvalid,
  input wire logic [7:0]  i_tone0_zero_cross,
  input wire logic [7:0]  i_tone0_peak,
  input wire logic [63:0] o_coef_select,
  input wire logic [23:0] o_channel_loop_ctrl_bits,
  input wire logic [63:0] o_teletax_gain_bits,
  input wire logic [95:0] o_tone0_frequency,
  input wire logic [7:0]  o_tone0_run
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_rd_ans; i_rd |=> o_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read strobe not answered");
  property p_coef; i_wr && i_addr == OFS_COEF_SEL
    |=> o_coef_select[8*$past(i_chan)+:8] == $past(i_wdata); endproperty
  a_coef: assert property (p_coef) else $error("coef select not stored");
  property p_loop; i_wr && i_addr == OFS_LOOP_IRQ
    |=> o_channel_loop_ctrl_bits[3*$past(i_chan)+:3] == $past(i_wdata[2:0]); endproperty
  a_loop: assert property (p_loop) else $error("loop bits not stored");
  property p_ttx; i_wr && i_addr == OFS_TTX_GAIN
    |=> o_teletax_gain_bits[8*$past(i_chan)+:8] == $past(i_wdata); endproperty
  a_ttx: assert property (p_ttx) else $error("teletax gain not stored");
  property p_t0lo; i_wr && i_addr == OFS_T0_LOW
    |=> o_tone0_frequency[12*$past(i_chan)+:8] == $past(i_wdata); endproperty
  a_t0lo: assert property (p_t0lo) else $error("tone0 low byte not stored");
  property p_keep; !(i_wr && i_addr == OFS_TTX_GAIN) |=> $stable(o_teletax_gain_bits); endproperty
  a_keep: assert property (p_keep) else $error("teletax gain changed unasked");
  property p_start; $rose(o_tone0_run[0]) |-> $past(i_tone0_zero_cross[0]); endproperty
  a_start: assert property (p_start) else $error("tone started off zero");
  property p_stop; $fell(o_tone0_run[0]) |-> $past(i_tone0_peak[0]); endproperty
  a_stop: assert property (p_stop) else $error("tone stopped off peak");
endmodule
bind channel_local_config_regs cfg_regs_monitor i_mon (.*);

// ---- tb/host_model.sv ----
/* Host side of the strobe port: one byte write or read per call.
   Expects the read answer one cycle after the strobe edge. */
`timescale 1ns/10ps
module host_model
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  output logic            o_wr,
  output logic            o_rd,
  output logic [2:0]      o_chan,
  output logic [2:0]      o_addr,
  output logic [7:0]      o_wdata
);
  initial {o_wr, o_rd, o_chan, o_addr, o_wdata} = '0;
  task automatic xfer(input logic w, input logic [2:0] c, input logic [2:0] a,
                      input logic [7:0] d, output logic [7:0] q, output logic v);
    @(posedge i_clk);
    o_wr    <= w;
    o_rd    <= !w;
    o_chan  <= c;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    @(posedge i_clk);
    q = i_rdata;
    v = i_rvalid;
  endtask
endmodule

// ---- tb/testbench.sv ----
/* Self-checking bench for the channel configuration bank.
   Short debounce step so the line scenarios stay brief. */
`timescale 1ns/10ps
module testbench;
  import chan_cfg_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_wr, i_rd, o_rvalid, v;
  logic [2:0]  i_chan, i_addr;
  logic [7:0]  i_wdata, o_rdata, q;
  logic [7:0]  i_hook_input = '0, i_ground_key_input = '0, i_tone0_zero_cross = '0;
  logic [7:0]  i_tone1_zero_cross = '0, i_tone0_peak = '0, i_tone1_peak = '0;
  logic [7:0]  i_bidir_line_pin_1 = '0, i_bidir_line_pin_2 = '0, i_pin1_is_input = '0;
  logic [7:0]  i_pin2_is_input = '0, o_receive_cutoff_bit, o_tone0_run, o_tone1_run;
  logic [7:0]  o_hook_debounced, o_ground_key_debounced, o_line_event;
  logic [63:0] o_coef_select, o_teletax_gain_bits;
  logic [23:0] o_channel_loop_ctrl_bits;
  logic [95:0] o_tone0_frequency, o_tone1_frequency;
  logic [47:0] o_tone_gain_bits;
  int          failures = 0, check_count = 0, ev_n = 0;
  host_model i_host (.i_clk(i_clk), .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_wr(i_wr),
    .o_rd(i_rd), .o_chan(i_chan), .o_addr(i_addr), .o_wdata(i_wdata));
  channel_local_config_regs #(.DEB_STEP(4)) i_dut (.*);
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_line_event[1] === 1'b1) ev_n <= ev_n + 1;
  task automatic give_verdict();
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [95:0] e, input logic [95:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // Unique per channel and offset; coef byte keeps bits 0 and 2 equal
  function automatic logic [7:0] val(int c, int a);
    return (a == 0) ? 8'hF5 ^ 8'(c * 32) : 8'(a * 32 + c * 4 + 2);
  endfunction
  task automatic t_defaults();
    for (int a = 0; a < 8; a++)
    begin
      i_host.xfer(1'b0, 3'h5, 3'(a), 8'h00, q, v);
      chk("rvalid", 1'b1, v);
      chk("reset value", (a == 0) ? 8'h08 : 8'h00, q);
    end
  endtask
  task automatic t_fields();
    for (int i = 0; i < 64; i++)
      i_host.xfer(1'b1, 3'(i / 8), 3'(i % 8), val(i / 8, i % 8), q, v);
    for (int i = 0; i < 64; i++)
    begin
      i_host.xfer(1'b0, 3'(i / 8), 3'(i % 8), 8'h00, q, v);
      chk("readback", val(i / 8, i % 8), q);
    end
    chk("coef", 8'h35, o_coef_select[48+:8]);
    chk("loop", 3'b010, o_channel_loop_ctrl_bits[18+:3]);
    chk("cutoff", 1'b1, o_receive_cutoff_bit[6]);
    chk("teletax", 8'h5A, o_teletax_gain_bits[48+:8]);
    chk("tone0 freq", 12'hA9A, o_tone0_frequency[72+:12]);
    chk("tone1 freq", 12'hDAB, o_tone1_frequency[72+:12]);
    chk("tone gain", 6'h3A, o_tone_gain_bits[36+:6]);
  endtask
  task automatic t_line();
    int n0;
    i_host.xfer(1'b1, 3'h1, OFS_DEBOUNCE, 8'h22, q, v);
    i_host.xfer(1'b1, 3'h1, OFS_LOOP_IRQ, 8'hC0, q, v);
    n0 = ev_n;
    i_hook_input[1] <= 1'b1;
    i_ground_key_input[1] <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk("early level", 2'b00, {o_hook_debounced[1], o_ground_key_debounced[1]});
    repeat (20) @(posedge i_clk);
    chk("late level", 2'b11, {o_hook_debounced[1], o_ground_key_debounced[1]});
    chk("event", 1'b1, ev_n > n0);
    i_host.xfer(1'b1, 3'h1, OFS_LOOP_IRQ, 8'h00, q, v);
    n0 = ev_n;
    i_hook_input[1] <= 1'b0;
    repeat (30) @(posedge i_clk);
    chk("masked level", 1'b0, o_hook_debounced[1]);
    chk("masked event", n0, ev_n);
  endtask
  task automatic t_pins();
    int n0;
    i_host.xfer(1'b1, 3'h1, OFS_LOOP_IRQ, 8'h20, q, v);
    n0 = ev_n;
    i_bidir_line_pin_1[1] <= 1'b1;
    repeat (8) @(posedge i_clk);
    chk("pin not input", n0, ev_n);
    i_pin1_is_input[1] <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_bidir_line_pin_1[1] <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk("pin event", 1'b1, ev_n == n0 + 1);
  endtask
  task automatic t_tone();
    chk("idle run", 2'b00, {o_tone1_run[0], o_tone0_run[0]});
    {i_tone1_zero_cross[0], i_tone0_zero_cross[0]} <= 2'b11;
    @(posedge i_clk);
    {i_tone1_zero_cross[0], i_tone0_zero_cross[0]} <= 2'b00;
    @(posedge i_clk);
    chk("started", 2'b11, {o_tone1_run[0], o_tone0_run[0]});
    i_host.xfer(1'b1, 3'h0, OFS_TONE_CTRL, 8'h00, q, v);
    chk("held to peak", 2'b11, {o_tone1_run[0], o_tone0_run[0]});
    {i_tone1_peak[0], i_tone0_peak[0]} <= 2'b11;
    @(posedge i_clk);
    {i_tone1_peak[0], i_tone0_peak[0]} <= 2'b00;
    @(posedge i_clk);
    chk("stopped", 2'b00, {o_tone1_run[0], o_tone0_run[0]});
  endtask
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_defaults();
    t_fields();
    t_line();
    t_pins();
    t_tone();
    give_verdict();
  end
  // Run needs about 510 cycles; generous margin
  initial
  begin
    #100000;
    failures++;
    give_verdict();
  end
endmodule
